/* logic/tcc_map.svh */
`ifndef TCC_MAP_SVH
`define TCC_MAP_SVH

////////////////////////////////////////////////////////////////////////////////
// Register indices; byte address is four times the index
`define TCC_IDX_COUNTER 16'hFF12
`define TCC_IDX_CC_FIRST 16'hFF14
`define TCC_IDX_CC_SECOND 16'hFF16
`define TCC_IDX_TIMER_MODE 16'hFF60
`define TCC_IDX_CC_CONTROL 16'hFF62
`define TCC_IDX_PRESCALER 16'hFF64
`define TCC_IDX_LSB 2
`define TCC_IDX_MSB 17

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define TCC_FIRST_MODE_BIT 0
`define TCC_FIRST_TRIG_BIT 1
`define TCC_SECOND_MODE_BIT 2
`define TCC_OVF_BIT 0
`define TCC_TMODE_LSB 1
`define TCC_TMODE_MSB 3
`define TCC_EDGE_A_LSB 4
`define TCC_EDGE_A_MSB 5
`define TCC_EDGE_B_LSB 6
`define TCC_EDGE_B_MSB 7

////////////////////////////////////////////////////////////////////////////////
// Reset values and edge codes
`define TCC_CC_RESET 16'h0000
`define TCC_COUNT_RESET 16'h0000
`define TCC_COUNT_MAX 16'hFFFF
`define TCC_CTRL_RESET 3'h0
`define TCC_TMODE_RESET 3'h0
`define TCC_EDGE_RESET 2'h0
`define TCC_EDGE_FALL 2'h0
`define TCC_EDGE_RISE 2'h1
`define TCC_EDGE_BOTH 2'h3

`endif

/* logic/tcc_pkg.sv */
package tcc_pkg;

  typedef logic [15:0] tcc_count_t;

  typedef enum logic [1:0] {
    TCC_STOP,
    TCC_FREE,
    TCC_CLEAR_INPUT,
    TCC_CLEAR_MATCH
  } tcc_run_mode_t;

endpackage : tcc_pkg

/* logic/tcc_cc_if.sv */
`timescale 1ns/1ps

interface tcc_cc_if;
  tcc_pkg::tcc_count_t count;
  logic tick;
  logic zero_ok;
  logic trigger;
  logic cap_mode;
  logic wr;
  tcc_pkg::tcc_count_t wdata;
  tcc_pkg::tcc_count_t value;
  logic irq;

  modport ctrl (
    output count, tick, zero_ok, trigger, cap_mode, wr, wdata,
    input value, irq
  );

  modport unit (
    input count, tick, zero_ok, trigger, cap_mode, wr, wdata,
    output value, irq
  );
endinterface : tcc_cc_if

/* logic/tcc_edge_det.sv */
`timescale 1ns/1ps

module tcc_edge_det (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  output logic rise,
  output logic fall
);

  logic [2:0] sync_q;

  // Three stages; edge counts when stages two and three differ
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync_q <= 3'h0;
    else
      sync_q <= {sync_q[1:0], pin};
  end

  assign rise = sync_q[1] & ~sync_q[2];
  assign fall = ~sync_q[1] & sync_q[2];

endmodule : tcc_edge_det

/* logic/tcc_cc_unit.sv */
`timescale 1ns/1ps
`include "tcc_map.svh"

module tcc_cc_unit (
  input wire logic pclk,
  input wire logic presetn,
  tcc_cc_if.unit cc
);

  tcc_pkg::tcc_count_t value_q;
  logic cap_pend_q;
  logic irq_q;
  logic capture;
  logic match;

  // Compare mode ignores triggers entirely
  assign capture = cc.cap_mode & cc.trigger;

  // Fires on the step away from the equal value, so once per event;
  // zero only counts after a wrap
  assign match = ~cc.cap_mode & cc.tick & (cc.count == value_q)
               & ((value_q != `TCC_CC_RESET) | cc.zero_ok);

  // Capture beats a same-cycle write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      value_q <= `TCC_CC_RESET;
    else if (capture)
      value_q <= cc.count;
    else if (cc.wr)
      value_q <= cc.wdata;
  end

  // Capture request follows the latch by one count clock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cap_pend_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      cap_pend_q <= capture;
      irq_q <= match | cap_pend_q;
    end
  end

  assign cc.value = value_q;
  assign cc.irq = irq_q;

endmodule : tcc_cc_unit

/* logic/tcc_timer_top.sv */
// Behaviour
// - First register: bit 0 picks compare/capture
// - First register clears to zero on reset
// - First compare equality raises first match request
// - Input A reverse phase; both-edges captures nothing
// - Input B captures on its selected edge
// - Edge fields at prescaler bits 5:4, 7:6
// - First zero matches at zero-to-one after wrap
// - Second zero matches at zero-to-one after wrap
// - Compare below count: counter wraps, keeps counting
// - Register contents undefined after timer stops
// - Compare-mode register ignores capture triggers
// - Capture wins over coinciding software write
// - Capture coinciding with stop is undefined
// - Second register: bit 2 picks compare/capture
// - Second register clears to zero on reset
// - Second compare equality raises second match request
// - Second captures on input A, same phase
// - Trigger select: 0 input B, 1 input A
// - Latch on count clock, request one later
// - Counter increments each count clock edge
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`include "tcc_map.svh"

module tcc_timer_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_input_a,
  input wire logic timer_input_b,
  output logic match_irq_first,
  output logic match_irq_second
);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations

  tcc_pkg::tcc_count_t up_counter_q;
  tcc_pkg::tcc_count_t up_counter_d;
  tcc_pkg::tcc_run_mode_t run_mode;
  logic [2:0] timer_mode_q;
  logic overflow_q;
  logic wrapped_q;
  logic first_mode_select_q;
  logic first_trigger_select_q;
  logic second_mode_select_q;
  logic [1:0] edge_a_q;
  logic [1:0] edge_b_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] rdata;
  logic hit;
  logic access;
  logic wr_fire;
  logic [15:0] idx;
  logic running;
  logic wrap;
  logic a_rise;
  logic a_fall;
  logic b_rise;
  logic b_fall;
  logic a_valid;
  logic a_reverse;
  logic b_valid;
  logic first_trig;
  logic clear_on_match;

  tcc_cc_if cc_first ();
  tcc_cc_if cc_second ();

  //////////////////////////////////////////////////////////////////////////////
  // Edge code decode

  function automatic logic edge_pick(
    input logic [1:0] code,
    input logic rise,
    input logic fall
  );
    logic hit_edge;
    hit_edge = 1'b0;
    case (code)
      `TCC_EDGE_FALL: hit_edge = fall;
      `TCC_EDGE_RISE: hit_edge = rise;
      `TCC_EDGE_BOTH: hit_edge = rise | fall;
      default: hit_edge = 1'b0;
    endcase
    return hit_edge;
  endfunction : edge_pick

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  tcc_edge_det u_edge_a (
    .pclk(pclk),
    .presetn(presetn),
    .pin(timer_input_a),
    .rise(a_rise),
    .fall(a_fall)
  );

  tcc_edge_det u_edge_b (
    .pclk(pclk),
    .presetn(presetn),
    .pin(timer_input_b),
    .rise(b_rise),
    .fall(b_fall)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Trigger selection

  assign a_valid = edge_pick(edge_a_q, a_rise, a_fall);
  assign b_valid = edge_pick(edge_b_q, b_rise, b_fall);

  always_comb
  begin
    case (edge_a_q)
      `TCC_EDGE_RISE: a_reverse = a_fall;
      `TCC_EDGE_FALL: a_reverse = a_rise;
      default: a_reverse = 1'b0;
    endcase
  end

  assign first_trig = first_trigger_select_q ? a_reverse : b_valid;

  // Stop cuts triggers; a racing stop is loose
  assign cc_first.trigger = running & first_trig;
  assign cc_second.trigger = running & a_valid;

  //////////////////////////////////////////////////////////////////////////////
  // Run mode

  always_comb
  begin
    case (timer_mode_q[2:1])
      2'h0: run_mode = tcc_pkg::TCC_STOP;
      2'h1: run_mode = tcc_pkg::TCC_FREE;
      2'h2: run_mode = tcc_pkg::TCC_CLEAR_INPUT;
      2'h3: run_mode = tcc_pkg::TCC_CLEAR_MATCH;
      default: run_mode = tcc_pkg::TCC_STOP;
    endcase
  end

  assign running = (run_mode != tcc_pkg::TCC_STOP);

  // Zero here would clear at once; software keeps it nonzero
  assign clear_on_match = (run_mode == tcc_pkg::TCC_CLEAR_MATCH)
                        & ~first_mode_select_q
                        & (up_counter_q == cc_first.value);

  //////////////////////////////////////////////////////////////////////////////
  // Counter

  // No clamp at the compare value; counting runs through the wrap
  assign wrap = running & ~clear_on_match & (up_counter_q == `TCC_COUNT_MAX);

  always_comb
  begin
    up_counter_d = up_counter_q + 16'h0001;
    case (run_mode)
      tcc_pkg::TCC_STOP: up_counter_d = `TCC_COUNT_RESET;
      tcc_pkg::TCC_CLEAR_INPUT:
        if (a_valid)
          up_counter_d = `TCC_COUNT_RESET;
      tcc_pkg::TCC_CLEAR_MATCH:
        if (clear_on_match)
          up_counter_d = `TCC_COUNT_RESET;
      default: up_counter_d = up_counter_q + 16'h0001;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      up_counter_q <= `TCC_COUNT_RESET;
    else
      up_counter_q <= up_counter_d;
  end

  // Zero compare arms only after a wrap
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wrapped_q <= 1'b0;
    else if (!running)
      wrapped_q <= 1'b0;
    else if (wrap)
      wrapped_q <= 1'b1;
  end

  // Overflow flag; a wrap in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      overflow_q <= 1'b0;
    else if (wrap)
      overflow_q <= 1'b1;
    else if (wr_fire && idx == `TCC_IDX_TIMER_MODE && !pwdata[`TCC_OVF_BIT])
      overflow_q <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Capture/compare units

  assign cc_first.count = up_counter_q;
  assign cc_first.tick = running;
  assign cc_first.wdata = pwdata[15:0];
  assign cc_second.count = up_counter_q;
  assign cc_second.tick = running;
  assign cc_second.wdata = pwdata[15:0];

  // Same zero arming for the second register
  assign cc_first.zero_ok = wrapped_q;
  assign cc_second.zero_ok = wrapped_q;

  assign cc_first.cap_mode = first_mode_select_q;
  assign cc_second.cap_mode = second_mode_select_q;

  // Whole word taken, byte lanes not split
  assign cc_first.wr = wr_fire & (idx == `TCC_IDX_CC_FIRST);
  assign cc_second.wr = wr_fire & (idx == `TCC_IDX_CC_SECOND);

  tcc_cc_unit u_cc_first (
    .pclk(pclk),
    .presetn(presetn),
    .cc(cc_first)
  );

  tcc_cc_unit u_cc_second (
    .pclk(pclk),
    .presetn(presetn),
    .cc(cc_second)
  );

  assign match_irq_first = cc_first.irq;
  assign match_irq_second = cc_second.irq;

  //////////////////////////////////////////////////////////////////////////////
  // APB slave

  assign idx = paddr[`TCC_IDX_MSB:`TCC_IDX_LSB];
  assign access = psel & penable & ~pready_q;
  assign wr_fire = psel & penable & pready_q & pwrite & hit;

  always_comb
  begin
    hit = (paddr[1:0] == 2'h0) && (paddr[31:18] == 14'h0000);
    rdata = 32'h00000000;
    case (idx)
      `TCC_IDX_COUNTER: rdata[15:0] = up_counter_q;
      // A racing capture makes this read loose
      `TCC_IDX_CC_FIRST: rdata[15:0] = cc_first.value;
      `TCC_IDX_CC_SECOND: rdata[15:0] = cc_second.value;
      `TCC_IDX_TIMER_MODE:
      begin
        rdata[`TCC_TMODE_MSB:`TCC_TMODE_LSB] = timer_mode_q;
        rdata[`TCC_OVF_BIT] = overflow_q;
      end
      `TCC_IDX_CC_CONTROL:
      begin
        rdata[`TCC_FIRST_MODE_BIT] = first_mode_select_q;
        rdata[`TCC_FIRST_TRIG_BIT] = first_trigger_select_q;
        rdata[`TCC_SECOND_MODE_BIT] = second_mode_select_q;
      end
      `TCC_IDX_PRESCALER:
      begin
        rdata[`TCC_EDGE_A_MSB:`TCC_EDGE_A_LSB] = edge_a_q;
        rdata[`TCC_EDGE_B_MSB:`TCC_EDGE_B_LSB] = edge_b_q;
      end
      default: hit = 1'b0;
    endcase
  end

  // One wait state keeps every answer registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= access;
      prdata_q <= (access && !pwrite) ? rdata : 32'h00000000;
      pslverr_q <= access & ~hit;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  //////////////////////////////////////////////////////////////////////////////
  // Control registers

  // Stored values stay put on stop; software must not rely on them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timer_mode_q <= `TCC_TMODE_RESET;
    else if (wr_fire && idx == `TCC_IDX_TIMER_MODE)
      timer_mode_q <= pwdata[`TCC_TMODE_MSB:`TCC_TMODE_LSB];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      first_mode_select_q <= 1'b0;
      first_trigger_select_q <= 1'b0;
      second_mode_select_q <= 1'b0;
    end
    else if (wr_fire && idx == `TCC_IDX_CC_CONTROL)
    begin
      first_mode_select_q <= pwdata[`TCC_FIRST_MODE_BIT];
      first_trigger_select_q <= pwdata[`TCC_FIRST_TRIG_BIT];
      second_mode_select_q <= pwdata[`TCC_SECOND_MODE_BIT];
    end
  end

  // Edge fields in the prescaler word
  // Code 10 is stored but selects no edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      edge_a_q <= `TCC_EDGE_RESET;
      edge_b_q <= `TCC_EDGE_RESET;
    end
    else if (wr_fire && idx == `TCC_IDX_PRESCALER)
    begin
      edge_a_q <= pwdata[`TCC_EDGE_A_MSB:`TCC_EDGE_A_LSB];
      edge_b_q <= pwdata[`TCC_EDGE_B_MSB:`TCC_EDGE_B_LSB];
    end
  end

endmodule : tcc_timer_top

/* verification/tcc_timer_asserts.sv */
`timescale 1ns/1ps
`include "tcc_map.svh"

module tcc_timer_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic timer_input_a,
  input wire logic timer_input_b,
  input wire logic match_irq_first,
  input wire logic match_irq_second
);
  logic wr_ok;
  logic [15:0] idx;
  logic [2:0] ctrl_q;
  logic [3:0] mode_q;
  logic [7:0] prm_q;
  logic [3:0] stop_q;
  assign wr_ok = psel && penable && pready && pwrite && !pslverr;
  assign idx = paddr[17:2];
  ////////////////////////////////////////////////////////////////////////////////
  // Shadow of settings, taken from completed writes only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= 3'h0;
      mode_q <= 4'h0;
      prm_q <= 8'h0;
    end
    else if (wr_ok)
    begin
      if (idx == `TCC_IDX_CC_CONTROL)
        ctrl_q <= pwdata[2:0];
      if (idx == `TCC_IDX_TIMER_MODE)
        mode_q <= pwdata[3:0];
      if (idx == `TCC_IDX_PRESCALER)
        prm_q <= pwdata[7:0];
    end
  end
  // Saturates so pending pulses can drain first
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stop_q <= 4'h0;
    else if (mode_q[3:2] != 2'h0)
      stop_q <= 4'h0;
    else if (stop_q != 4'hF)
      stop_q <= stop_q + 4'h1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_one_wait: assert property (psel && !penable ##1 psel && penable |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  chk_idle_rdata: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside answer");
  chk_unmapped_err: assert property (pready && !(idx inside {`TCC_IDX_COUNTER,
    `TCC_IDX_CC_FIRST, `TCC_IDX_CC_SECOND, `TCC_IDX_TIMER_MODE, `TCC_IDX_CC_CONTROL,
    `TCC_IDX_PRESCALER}) |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_first_pulse: assert property (match_irq_first |=> !match_irq_first)
    else $error("first request longer than one cycle");
  chk_second_pulse: assert property (match_irq_second |=> !match_irq_second)
    else $error("second request longer than one cycle");
  chk_stop_quiet: assert property (stop_q == 4'hF |->
    !match_irq_first && !match_irq_second)
    else $error("request while stopped");
  chk_cap_second: assert property (mode_q[3:2] == 2'h1 && ctrl_q[2] &&
    prm_q[5:4] == `TCC_EDGE_RISE && $rose(timer_input_a) |-> ##[2:5] match_irq_second)
    else $error("second capture request missing");
  chk_rev_both: assert property (ctrl_q[1:0] == 2'h3 && prm_q[5:4] == 2'h3
    |-> !match_irq_first)
    else $error("reverse both-edge capture fired");
  chk_reset_quiet: assert property ($rose(presetn) |->
    !pready && !match_irq_first && !match_irq_second)
    else $error("outputs active after reset");
  cov_cap: cover property (match_irq_second && ctrl_q[2]);
  cov_clear: cover property (match_irq_first && mode_q[3:2] == 2'h3);
  cov_err: cover property (pready && pslverr);
endmodule : tcc_timer_asserts

bind tcc_timer_top tcc_timer_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer_input_a(timer_input_a), .timer_input_b(timer_input_b),
  .match_irq_first(match_irq_first), .match_irq_second(match_irq_second)
);

/* verification/tcc_pin_src.sv */
`timescale 1ns/1ps

module tcc_pin_src (
  input wire logic pclk,
  output logic pin_a,
  output logic pin_b
);
  initial
  begin
    pin_a = 1'b0;
    pin_b = 1'b0;
  end
  // Levels move just after an edge; callers keep them for many clocks
  task set_pin(input logic sel, input logic lvl);
    @(posedge pclk);
    if (sel)
      pin_b <= lvl;
    else
      pin_a <= lvl;
  endtask : set_pin
endmodule : tcc_pin_src

/* verification/tcc_tb.sv */
`timescale 1ns/1ps
`include "tcc_map.svh"

module tb;
  localparam logic [15:0] FIRST = `TCC_IDX_CC_FIRST;
  localparam logic [15:0] SECOND = `TCC_IDX_CC_SECOND;
  localparam logic [15:0] MODE = `TCC_IDX_TIMER_MODE;
  localparam logic [15:0] CTRL = `TCC_IDX_CC_CONTROL;
  localparam logic [15:0] PRM = `TCC_IDX_PRESCALER;
  localparam logic [15:0] CNT = `TCC_IDX_COUNTER;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, c1;
  logic pready, pslverr, err, ia, ib, irq1, irq2;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  int t1, t2;
  // code 10 never used; {ctrl, prm, pin, level, irq, count}
  logic [15:0] tbl [14] = '{16'h1009, 16'h100C, 16'h140D, 16'h1C09, 16'h3101, 16'h3104,
    16'h3005, 16'h3304, 16'h3300, 16'h4003, 16'h4107, 16'h4307, 16'h040C, 16'h0106};
  always #5 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  tcc_timer_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_input_a(ia), .timer_input_b(ib), .match_irq_first(irq1),
    .match_irq_second(irq2));
  tcc_pin_src SRC (.pclk(pclk), .pin_a(ia), .pin_b(ib));
  ////////////////////////////////////////////////////////////////////////////////
  task apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {14'h0, idx, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Sampled mid-cycle, after the launching edge has settled
  task wait_irq(input logic sel, output int t);
    int n;
    n = 0;
    do
    begin
      @(negedge pclk);
      n++;
    end
    while ((sel ? irq2 : irq1) !== 1'b1 && n < 70000);
    t = cyc;
    if (n >= 70000)
      chk(32'h0, 32'h1);
  endtask : wait_irq
  // Config only while stopped; baseline level set first
  task edge_case(input logic [15:0] e);
    int n;
    apb(1'b1, MODE, 32'h0);
    SRC.set_pin(e[3], ~e[2]);
    repeat (16) @(posedge pclk);
    apb(1'b1, FIRST, 32'hF000);
    apb(1'b1, SECOND, 32'hF000);
    apb(1'b1, PRM, {24'h0, e[11:4]});
    apb(1'b1, CTRL, {28'h0, e[15:12]});
    apb(1'b1, MODE, 32'h4);
    repeat (6) @(posedge pclk);
    SRC.set_pin(e[3], e[2]);
    n = 0;
    repeat (10)
    begin
      @(negedge pclk);
      if ((e[1] ? irq2 : irq1) === 1'b1)
        n++;
    end
    chk(32'(n), {31'h0, e[0]});
  endtask : edge_case
  task tally_and_finish();
    $display("compares %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #900000;
    failures++;
    tally_and_finish();
  end
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, FIRST, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, SECOND, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 16'h0001, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, FIRST, 32'hABCD1234);
    apb(1'b0, FIRST, 32'h0);
    chk(rd, 32'h1234);
    $display("test registers done");
    apb(1'b1, FIRST, 32'h20);
    apb(1'b1, SECOND, 32'h30);
    apb(1'b1, MODE, 32'h4);
    wait_irq(1'b0, t1);
    wait_irq(1'b1, t2);
    chk(32'(t2 - t1), 32'h10);
    apb(1'b1, MODE, 32'h0);
    apb(1'b1, FIRST, 32'h10);
    apb(1'b1, MODE, 32'hC);
    wait_irq(1'b0, t1);
    wait_irq(1'b0, t2);
    chk(32'(t2 - t1), 32'h11);
    $display("test compare done");
    apb(1'b1, MODE, 32'h0);
    apb(1'b1, FIRST, 32'h0);
    apb(1'b1, SECOND, 32'h0);
    apb(1'b1, MODE, 32'h4);
    t1 = cyc;
    wait_irq(1'b0, t2);
    chk(32'(t2 - t1 > 65000), 32'h1);
    chk({31'h0, irq2}, 32'h1);
    apb(1'b0, MODE, 32'h0);
    chk(rd & 32'h1, 32'h1);
    $display("test zero wrap done");
    apb(1'b1, MODE, 32'h0);
    apb(1'b0, MODE, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, PRM, 32'h40);
    apb(1'b1, CTRL, 32'h1);
    apb(1'b1, MODE, 32'h4);
    apb(1'b0, CNT, 32'h0);
    c1 = rd;
    SRC.set_pin(1'b1, 1'b1);
    wait_irq(1'b0, t1);
    apb(1'b0, CNT, 32'h0);
    t2 = int'(rd);
    apb(1'b0, FIRST, 32'h0);
    chk(32'(rd > c1 && int'(rd) < t2), 32'h1);
    $display("test capture value done");
    foreach (tbl[i])
      edge_case(tbl[i]);
    $display("test edges done");
    apb(1'b1, MODE, 32'h0);
    SRC.set_pin(1'b0, 1'b0);
    apb(1'b1, MODE, 32'h8);
    repeat (40) @(posedge pclk);
    SRC.set_pin(1'b0, 1'b1);
    repeat (8) @(posedge pclk);
    apb(1'b0, CNT, 32'h0);
    chk(32'(rd < 32'h10), 32'h1);
    $display("test clear on input done");
    apb(1'b1, FIRST, 32'h55);
    apb(1'b1, SECOND, 32'h66);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, FIRST, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, SECOND, 32'h0);
    chk(rd, 32'h0);
    $display("test reset done");
    tally_and_finish();
  end
endmodule : tb
